// file: logic/drb_pkg.sv
// Purpose: shared constants and the register-bus slave of the read-burst block
// Assumes: AXI4-Lite master keeps to one write and one read in flight
// Notes:   byte address bits [7:0] decode the register map
package drb_pkg;
	localparam int           PIPE_DEPTH  = 16;
	localparam int           ADDR_BITS   = 14;
	localparam int           AP_BIT      = 10;
	localparam int           BL_LSB      = 0;
	localparam int           CL_LSB      = 4;
	localparam int           AL_LSB      = 3;
	localparam logic [2:0]   BL_CODE4    = 3'h2;
	localparam logic [2:0]   BL_CODE8    = 3'h3;
	localparam logic [2:0]   CL_MIN      = 3'h3;
	localparam logic [2:0]   AL_MAX      = 3'h6;
	localparam logic [2:0]   CL_RESET    = 3'h3;
	localparam logic [2:0]   AL_RESET    = 3'h0;
	localparam logic         BL8_RESET   = 1'b0;
	localparam logic [3:0]   BEATS4      = 4'h4;
	localparam logic [3:0]   BEATS8      = 4'h8;
	localparam logic [3:0]   HALF4       = 4'h2;
	localparam logic [3:0]   HALF8       = 4'h4;
	localparam logic [7:0]   ADDR_CTRL   = 8'h00;
	localparam logic [7:0]   ADDR_MODE   = 8'h04;
	localparam logic [7:0]   ADDR_STATUS = 8'h08;
	localparam logic [7:0]   ADDR_RDCNT  = 8'h0c;
	localparam logic [7:0]   ADDR_SEED   = 8'h10;
	localparam logic         CTRL_RESET  = 1'b1;
	localparam logic [7:0]   SEED_RESET  = 8'h00;
	localparam logic [1:0]   RESP_OKAY   = 2'h0;
	localparam logic [1:0]   RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {DRB_NOP, DRB_ACT, DRB_READ, DRB_PRE, DRB_LOAD} drb_cmd_t;
endpackage

`timescale 1ns/1ps
module drb_axil_slave
	import drb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wrPulse,
	output logic [7:0]       wrAddr,
	output logic [31:0]      wrData,
	output logic [3:0]       wrStrb,
	input  wire logic        wrHit,
	output logic [7:0]       rdAddr,
	input  wire logic [31:0] rdData,
	input  wire logic        rdHit
);
	// readies are flops of their own; a held channel is simply one whose ready is low
	wire awHeld = !s_axi_awready;
	wire wHeld  = !s_axi_wready;
	wire arHeld = !s_axi_arready;
	wire wrGo   = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_arready <= 1'b1;
			wrPulse      <= 1'b0;
			wrAddr       <= 8'h00;
			wrData       <= 32'h0;
			wrStrb       <= 4'h0;
			rdAddr       <= 8'h00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0;
		end else begin
			wrPulse <= wrGo && wrHit;
			if (s_axi_awvalid && !awHeld) begin
				s_axi_awready <= 1'b0;
				wrAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld) begin
				s_axi_wready <= 1'b0;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end
			if (wrGo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && !arHeld) begin
				s_axi_arready <= 1'b0;
				rdAddr <= s_axi_araddr;
			end else if (arHeld && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdHit ? rdData : 32'h0;
				s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// file: logic/drb_read_burst.sv
// Purpose: read path of a double-data-rate memory device behind its command pins
// Assumes: command pins settle at the falling edge of the command clock
// Notes:   data is a pattern from column, seed and beat, not a stored array
// Functional notes
// (R1) controller gives column, bank, autoprecharge per read
// (R2) autoprecharge closes row after burst, else open
// (R3) first data read_latency clocks after read
// (R4) latencies loaded by mode commands, used here
// (R5) later elements on every clock crossing
// (R6) strobe pair driven, preamble low/high first
// (R7) postamble low/high after final element
// (R8) outputs float once burst completes
// (R9) read half burst later concatenates seamlessly
// (R10) four-beat bursts never interrupted
// (R11) eight-beat burst truncated only by read
// (R12) truncating read exactly two clocks later
// (R13) only nop between truncated reads, no precharge
// (R14) truncated read must lack autoprecharge
// (R15) read data completes before any write burst
// (R16) precharge spacing: latency plus half burst
// (R17) precharge time from last prefetch edge
// (R18) no bank command within precharge period
// (R19) read to precharge minimum spacing formula
// (R20) controller rounds times up to clocks
// (R21) controller tracks rows and read cycles
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module drb_read_burst
	import drb_pkg::*;
#(
	parameter int BANKS = 8
)(
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 ckPin,
	input  wire logic                 csPin_n,
	input  wire logic                 rasPin_n,
	input  wire logic                 casPin_n,
	input  wire logic                 wePin_n,
	input  wire logic [2:0]           bankPin,
	input  wire logic [ADDR_BITS-1:0] addrPin,
	output logic [7:0]                dqOut,
	output logic                      dqOe,
	output logic                      dqsOut,
	output logic                      dqsNOut,
	output logic                      dqsOe,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	if (BANKS < 1 || BANKS > 8) begin : g_bad_banks
		$error("BANKS must lie in 1..8");
	end

	localparam int PW = 4 + 3 + ADDR_BITS;
	logic [PW-1:0] pinS1_reg;
	logic [PW-1:0] pinS2_reg;
	logic          ckS1_reg;
	logic          ckS2_reg;
	logic          ckS3_reg;
	logic          enable_reg;
	logic [7:0]    seed_reg;
	logic [2:0]    cl_reg;
	logic [2:0]    al_reg;
	logic          bl8_reg;
	logic [15:0]   rdCount_reg;
	logic [BANKS-1:0] rowOpen_reg;
	logic [3:0]    beatsLeft_reg;
	logic [7:0]    beatData_reg;
	logic          post_reg;
	logic [PIPE_DEPTH-1:0] pipeV_reg;
	logic [PIPE_DEPTH-1:0] pipeB8_reg;
	logic [7:0]    pipeD_reg [PIPE_DEPTH];
	logic          wrPulse;
	logic [7:0]    wrAddr;
	logic [31:0]   wrData;
	logic [3:0]    wrStrb;
	logic [7:0]    rdAddr;

	// only the second stage is looked at; the third is for the edge finder
	always_ff @(posedge clk) begin
		if (srst) begin
			ckS1_reg  <= 1'b0;
			ckS2_reg  <= 1'b0;
			ckS3_reg  <= 1'b0;
			pinS1_reg <= '1;
			pinS2_reg <= '1;
		end else begin
			ckS1_reg  <= ckPin;
			ckS2_reg  <= ckS1_reg;
			ckS3_reg  <= ckS2_reg;
			pinS1_reg <= {csPin_n, rasPin_n, casPin_n, wePin_n, bankPin, addrPin};
			pinS2_reg <= pinS1_reg;
		end
	end

	wire riseEv = ckS2_reg && !ckS3_reg;
	wire fallEv = !ckS2_reg && ckS3_reg;
	wire [3:0] cmdBits = pinS2_reg[PW-1 -: 4];
	wire [2:0] cmdBank = pinS2_reg[ADDR_BITS +: 3];
	wire [ADDR_BITS-1:0] cmdAddr = pinS2_reg[ADDR_BITS-1:0];
	drb_cmd_t cmdKind;
	always_comb begin
		case (cmdBits)
			4'b0011: cmdKind = DRB_ACT;
			4'b0101: cmdKind = DRB_READ;
			4'b0010: cmdKind = DRB_PRE;
			4'b0000: cmdKind = DRB_LOAD;
			default: cmdKind = DRB_NOP;
		endcase
	end
	wire cmdTake = riseEv && enable_reg;
	wire rdTake  = cmdTake && cmdKind == DRB_READ;
	wire apSel   = cmdAddr[AP_BIT];                      // [R1]
	wire loadPri = cmdTake && cmdKind == DRB_LOAD && cmdBank == 3'h0;
	wire loadExt = cmdTake && cmdKind == DRB_LOAD && cmdBank == 3'h1;
	wire [2:0] newBl = cmdAddr[BL_LSB +: 3];
	wire [2:0] newCl = cmdAddr[CL_LSB +: 3];
	wire [2:0] newAl = cmdAddr[AL_LSB +: 3];
	wire [3:0] rl    = {1'b0, al_reg} + {1'b0, cl_reg};
	wire [3:0] half  = bl8_reg ? HALF8 : HALF4;
	wire [3:0] apDelay = {1'b0, al_reg} + half;
	wire [7:0] rdBase = cmdAddr[7:0] + seed_reg;

	// latencies come only from mode loads on the command pins
	always_ff @(posedge clk) begin
		if (srst) begin
			cl_reg  <= CL_RESET;
			al_reg  <= AL_RESET;
			bl8_reg <= BL8_RESET;
		end else begin
			if (loadPri && newCl >= CL_MIN) cl_reg <= newCl;    // [R4]
			if (loadPri && (newBl == BL_CODE4 || newBl == BL_CODE8))
				bl8_reg <= newBl == BL_CODE8;
			if (loadExt && newAl <= AL_MAX) al_reg <= newAl;    // [R4]
		end
	end

	// entry enters at slot rl-1 and reaches slot 0 one edge before its first beat
	for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
		wire ins = rdTake && rl == 4'(i + 1);
		if (i == PIPE_DEPTH - 1) begin : g_top
			always_ff @(posedge clk) begin
				if (srst) pipeV_reg[i] <= 1'b0;
				else if (riseEv) pipeV_reg[i] <= ins;
			end
		end else begin : g_mid
			always_ff @(posedge clk) begin
				if (srst) pipeV_reg[i] <= 1'b0;
				else if (riseEv) pipeV_reg[i] <= ins || pipeV_reg[i+1];   // [R3]
			end
		end
		always_ff @(posedge clk) begin
			if (riseEv && ins) begin
				pipeB8_reg[i] <= bl8_reg;
				pipeD_reg[i]  <= rdBase;
			end else if (riseEv && i < PIPE_DEPTH - 1) begin
				pipeB8_reg[i] <= pipeB8_reg[(i + 1) % PIPE_DEPTH];
				pipeD_reg[i]  <= pipeD_reg[(i + 1) % PIPE_DEPTH];
			end
		end
	end

	// per-bank open row and the autoprecharge countdown
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic [3:0] apCnt_reg;
		wire hit = cmdBank == 3'(b);
		always_ff @(posedge clk) begin
			if (srst) begin
				apCnt_reg      <= 4'h0;
				rowOpen_reg[b] <= 1'b0;
			end else if (riseEv) begin
				if (cmdTake && cmdKind == DRB_ACT && hit) rowOpen_reg[b] <= 1'b1;
				else if (cmdTake && cmdKind == DRB_PRE && (hit || apSel)) rowOpen_reg[b] <= 1'b0;
				else if (apCnt_reg == 4'h1) rowOpen_reg[b] <= 1'b0;          // [R2]
				if (rdTake && hit && apSel) apCnt_reg <= apDelay;            // [R2]
				else if (rdTake && hit) apCnt_reg <= 4'h0;
				else if (apCnt_reg != 4'h0) apCnt_reg <= apCnt_reg - 4'h1;
			end
		end
		chk_autopre_close: assert property (@(posedge clk) disable iff (srst)    // [R2]
			riseEv && apCnt_reg == 4'h1 && !(cmdTake && cmdKind == DRB_ACT && hit)
			|=> !rowOpen_reg[b])
			else $error("row not closed after autoprecharge delay");
	end

	// a new burst at slot 0 overrides what is left: concatenation and truncation
	wire startBurst = riseEv && pipeV_reg[0];
	always_ff @(posedge clk) begin
		if (srst) begin
			dqOut         <= 8'h00;
			dqOe          <= 1'b0;
			dqsOut        <= 1'b0;
			dqsNOut       <= 1'b1;
			dqsOe         <= 1'b0;
			beatsLeft_reg <= 4'h0;
			beatData_reg  <= 8'h00;
			post_reg      <= 1'b0;
		end else if (startBurst) begin                 // [R3] [R9] [R11]
			dqOut         <= pipeD_reg[0];
			dqOe          <= 1'b1;
			dqsOut        <= 1'b1;
			dqsNOut       <= 1'b0;
			dqsOe         <= 1'b1;
			beatsLeft_reg <= (pipeB8_reg[0] ? BEATS8 : BEATS4) - 4'h1;
			beatData_reg  <= pipeD_reg[0] + 8'h01;
			post_reg      <= 1'b0;
		end else if ((riseEv || fallEv) && beatsLeft_reg != 4'h0) begin   // [R5]
			dqOut         <= beatData_reg;
			dqsOut        <= riseEv;
			dqsNOut       <= !riseEv;
			beatsLeft_reg <= beatsLeft_reg - 4'h1;
			beatData_reg  <= beatData_reg + 8'h01;
		end else if (riseEv && dqOe) begin
			dqOe          <= 1'b0;                                           // [R8]
			dqsOut        <= 1'b0;                                           // [R7]
			dqsNOut       <= 1'b1;
			post_reg      <= 1'b1;
		end else if (riseEv && pipeV_reg[1]) begin
			dqsOe         <= 1'b1;                                           // [R6]
			dqsOut        <= 1'b0;
			dqsNOut       <= 1'b1;
		end else if (fallEv && post_reg) begin
			post_reg      <= 1'b0;
			if (!pipeV_reg[0]) dqsOe <= 1'b0;      // a waiting burst keeps it as preamble
		end
	end

	always_ff @(posedge clk) begin
		if (srst) rdCount_reg <= 16'h0;
		else if (rdTake) rdCount_reg <= rdCount_reg + 16'h1;
	end

	// register map
	wire wrHit = wrAddr == ADDR_CTRL || wrAddr == ADDR_SEED;
	wire rdHit = rdAddr == ADDR_CTRL || rdAddr == ADDR_SEED || rdAddr == ADDR_MODE
		|| rdAddr == ADDR_STATUS || rdAddr == ADDR_RDCNT;
	wire [31:0] modeWord = {24'h0, bl8_reg, al_reg, 1'b0, cl_reg};
	wire [31:0] statWord = {15'h0, (beatsLeft_reg != 4'h0), 8'h0, 8'(rowOpen_reg)};
	wire [31:0] rdData = rdAddr == ADDR_CTRL ? {31'h0, enable_reg}
		: rdAddr == ADDR_SEED ? {24'h0, seed_reg}
		: rdAddr == ADDR_MODE ? modeWord
		: rdAddr == ADDR_STATUS ? statWord
		: {16'h0, rdCount_reg};
	always_ff @(posedge clk) begin
		if (srst) begin
			enable_reg <= CTRL_RESET;
			seed_reg   <= SEED_RESET;
		end else if (wrPulse && wrStrb[0]) begin
			if (wrAddr == ADDR_CTRL) enable_reg <= wrData[0];
			if (wrAddr == ADDR_SEED) seed_reg <= wrData[7:0];
		end
	end

	drb_axil_slave u_bus (
		.clk           (clk),
		.srst          (srst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrPulse       (wrPulse),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrHit         (wrHit),
		.rdAddr        (rdAddr),
		.rdData        (rdData),
		.rdHit         (rdHit)
	);

	sequence sBurstStart;
		riseEv && pipeV_reg[0];
	endsequence
	sequence sDriveFirst;
		dqOe && dqsOe && dqsOut;
	endsequence

	chk_first_beat: assert property (@(posedge clk) disable iff (srst)         // [R3]
		sBurstStart |=> sDriveFirst)
		else $error("first beat not driven at latency edge");
	chk_read_enqueue: assert property (@(posedge clk) disable iff (srst)       // [R3]
		rdTake |=> pipeV_reg[$past(rl) - 4'h1])
		else $error("read not queued at latency slot");
	chk_mode_load: assert property (@(posedge clk) disable iff (srst)          // [R4]
		loadPri && newCl >= CL_MIN |=> cl_reg == $past(newCl))
		else $error("cas latency not loaded");
	chk_beat_edges: assert property (@(posedge clk) disable iff (srst)         // [R5]
		dqOe && $changed(dqOut) |-> $past(riseEv || fallEv))
		else $error("data changed away from a clock crossing");
	chk_strobe_pair: assert property (@(posedge clk) disable iff (srst)        // [R6]
		dqsOe |-> dqsOut != dqsNOut)
		else $error("strobe pair not complementary");
	chk_preamble_level: assert property (@(posedge clk) disable iff (srst)     // [R6]
		riseEv && pipeV_reg[1] && !pipeV_reg[0] && beatsLeft_reg == 4'h0 && !dqOe
		|=> dqsOe && !dqsOut && dqsNOut)
		else $error("preamble not driven");
	chk_postamble_low: assert property (@(posedge clk) disable iff (srst)      // [R7]
		riseEv && dqOe && beatsLeft_reg == 4'h0 && !pipeV_reg[0]
		|=> dqsOe && !dqsOut && !dqOe)
		else $error("postamble not driven low");
	chk_float_release: assert property (@(posedge clk) disable iff (srst)      // [R8]
		fallEv && post_reg && !pipeV_reg[0] |=> !dqsOe ##1 !dqsOe)
		else $error("strobe not released after postamble");
	chk_truncate_reload: assert property (@(posedge clk) disable iff (srst)    // [R11]
		sBurstStart ##0 pipeB8_reg[0] |=> beatsLeft_reg == 4'h7)
		else $error("new burst did not reload beat count");
endmodule

// file: testbench/drb_ctrl_model.sv
// Purpose: controller model: makes the command clock, issues commands, captures strobed beats
// Assumes: command clock period is eight system clocks
// Notes:   pins change at the command clock fall so they are steady at its rise
`timescale 1ns/1ps
module drb_ctrl_model
	import drb_pkg::*;
(
	input  wire logic            clk,
	output logic                 ckPin,
	output logic                 csPin_n,
	output logic                 rasPin_n,
	output logic                 casPin_n,
	output logic                 wePin_n,
	output logic [2:0]           bankPin,
	output logic [ADDR_BITS-1:0] addrPin,
	input  wire logic [7:0]      dqOut,
	input  wire logic            dqOe,
	input  wire logic            dqsOut,
	input  wire logic            dqsNOut,
	input  wire logic            dqsOe
);
	logic [2:0] ph = 3'h0;
	logic       prevOe = 1'b0;
	logic       prevDqs = 1'b0;
	logic       prevDqsN = 1'b1;
	logic       prevDqsOe = 1'b0;
	logic [7:0] beatQ [$];
	longint     firstT;
	int         oeFalls = 0;
	int         ambleBad = 0;
	initial begin
		ckPin = 1'b1;
		{csPin_n, rasPin_n, casPin_n, wePin_n} = 4'h7;
		bankPin = 3'h0;
		addrPin = '0;
	end
	always @(posedge clk) begin
		ph <= ph + 3'h1;
		if (ph == 3'h3) ckPin <= 1'b0;
		if (ph == 3'h7) ckPin <= 1'b1;
	end
	// a beat is any strobe toggle while data is driven
	always @(posedge clk) begin
		if (dqOe === 1'b1 && (prevOe !== 1'b1 || dqsOut !== prevDqs)) begin
			if (beatQ.size() == 0) firstT = $time;
			if (prevOe !== 1'b1 && !(prevDqsOe === 1'b1 && prevDqs === 1'b0 && prevDqsN === 1'b1))
				ambleBad++;
			beatQ.push_back(dqOut);
		end
		if (prevOe === 1'b1 && dqOe !== 1'b1) begin
			oeFalls++;
			if (!(dqsOe === 1'b1 && dqsOut === 1'b0 && dqsNOut === 1'b1)) ambleBad++;
		end
		prevOe = dqOe;
		prevDqs = dqsOut;
		prevDqsN = dqsNOut;
		prevDqsOe = dqsOe;
	end
	// one command per command-clock period; no write command exists, so reads finish
	// back-to-back calls put two commands exactly two command clocks apart
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [ADDR_BITS-1:0] a);
		@(posedge clk);
		while (ph !== 3'h3) @(posedge clk);
		{csPin_n, rasPin_n, casPin_n, wePin_n} <= c;
		bankPin <= b;
		addrPin <= a;
		@(posedge clk);
		while (ph !== 3'h3) @(posedge clk);
		{csPin_n, rasPin_n, casPin_n, wePin_n} <= 4'h7;
		bankPin <= ~b;
		addrPin <= ~a;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			while (ph !== 3'h3) @(posedge clk);
		end
	endtask
endmodule

// file: testbench/drb_read_burst_tb.sv
// Purpose: self-checking bench for the read-burst block
// Assumes: command clock runs at eight system clocks per period
// Notes:   ordinary reads come from a table, odd cases follow by hand
`timescale 1ns/1ps
module drb_read_burst_tb
	import drb_pkg::*;
;
	typedef struct packed {
		logic [2:0] al;
		logic [2:0] cl;
		logic       bl8;
		logic       ap;
		logic [7:0] col;
		logic [3:0] beats;
		logic       rowOpen;
	} drb_row_t;
	logic clk = 1'b0, srst = 1'b1, ckPin, csPin_n, rasPin_n, casPin_n, wePin_n;
	logic [2:0] bankPin;
	logic [ADDR_BITS-1:0] addrPin;
	logic [7:0] dqOut, s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, seed = 8'h5a;
	logic dqOe, dqsOut, dqsNOut, dqsOe, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int miscompares = 0, totalChecks = 0;
	longint tRise;
	logic [7:0] rstAddr [4] = '{ADDR_CTRL, ADDR_MODE, ADDR_SEED, ADDR_STATUS};
	logic [31:0] rstVal [4] = '{32'h1, 32'h3, 32'h0, 32'h0};
	drb_row_t rows [5] = '{
		{3'h0, 3'h3, 1'b0, 1'b0, 8'h10, 4'h4, 1'b1},
		{3'h0, 3'h5, 1'b1, 1'b1, 8'hfe, 4'h8, 1'b0},
		{3'h2, 3'h4, 1'b0, 1'b1, 8'h33, 4'h4, 1'b0},
		{3'h6, 3'h7, 1'b1, 1'b0, 8'h80, 4'h8, 1'b1},
		{3'h1, 3'h3, 1'b0, 1'b0, 8'hff, 4'h4, 1'b1}};
	drb_read_burst #(.BANKS(8)) dut (.*);
	drb_ctrl_model ctl (.*);
	always #10 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic printVerdict;
		$display("checks %0d miscompares %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		// let an edge pass so a following call never re-raises bready in the same step
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic setMode(input logic [2:0] al, input logic [2:0] cl, input logic bl8);
		ctl.issue(4'h0, 3'h0, {7'h0, cl, 1'b0, bl8 ? BL_CODE8 : BL_CODE4});
		ctl.issue(4'h0, 3'h1, {8'h0, al, 3'h0});
		axiRead(ADDR_MODE);
		check(rd, 32'({bl8, al, 1'b0, cl}));
	endtask
	task automatic clearCap;
		ctl.beatQ.delete();
		ctl.oeFalls = 0;
		ctl.ambleBad = 0;
	endtask
	// bounded wait for the data enable to drop, then for the strobe to let go
	task automatic waitDone;
		for (int k = 0; k < 600 && ctl.oeFalls == 0; k++) @(posedge clk);
		repeat (8) @(posedge clk);
		check(32'({dqOe, dqsOe}), 32'h0);
	endtask
	task automatic checkBeats(input logic [7:0] c0, input int n0, input logic [7:0] c1, input int n1);
		check(32'(ctl.beatQ.size()), 32'(n0 + n1));
		for (int n = 0; n < n0 + n1 && n < ctl.beatQ.size(); n++)
			check(32'(ctl.beatQ[n]), 32'(n < n0 ? 8'(c0 + seed + 8'(n)) : 8'(c1 + seed + 8'(n - n0))));
		check(32'(ctl.ambleBad), 32'h0);
		check(32'(ctl.oeFalls), 32'h1);
	endtask
	initial begin
		#1ms;
		miscompares++;
		printVerdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			axiRead(rstAddr[i]);
			check(rd, rstVal[i]);
		end
		axiWrite(ADDR_SEED, 32'(seed));
		check(32'(resp), 32'(RESP_OKAY));
		for (int i = 0; i < 5; i++) begin
			setMode(rows[i].al, rows[i].cl, rows[i].bl8);
			ctl.issue(4'h3, 3'(i), 14'h0001);
			clearCap();
			ctl.issue(4'h5, 3'(i), {3'h0, rows[i].ap, 2'h0, rows[i].col});
			tRise = $time - 80;
			waitDone();
			checkBeats(rows[i].col, int'(rows[i].beats), 8'h0, 0);
			check(32'((ctl.firstT - tRise) / 160), 32'(rows[i].al) + 32'(rows[i].cl));
			axiRead(ADDR_STATUS);
			check(32'(rd[i]), 32'(rows[i].rowOpen));
		end
		// reads half a burst apart must join into one unbroken stream
		setMode(3'h0, 3'h3, 1'b0);
		clearCap();
		ctl.issue(4'h5, 3'h0, 14'h0020);
		ctl.issue(4'h5, 3'h0, 14'h0040);
		waitDone();
		checkBeats(8'h20, 4, 8'h40, 4);
		// an eight-beat read cut short by a read two clocks later
		setMode(3'h0, 3'h3, 1'b1);
		clearCap();
		ctl.issue(4'h5, 3'h0, 14'h0060);
		ctl.issue(4'h5, 3'h3, 14'h0490);
		waitDone();
		checkBeats(8'h60, 4, 8'h90, 8);
		ctl.idle(2);
		ctl.issue(4'h2, 3'h0, 14'h0400);
		ctl.idle(4);
		axiRead(ADDR_STATUS);
		check(rd & 32'hff, 32'h0);
		ctl.issue(4'h0, 3'h1, {8'h0, 3'h7, 3'h0});
		axiRead(ADDR_MODE);
		check(rd, 32'h83);
		axiWrite(ADDR_CTRL, 32'h0);
		clearCap();
		ctl.issue(4'h5, 3'h0, 14'h0000);
		repeat (300) @(posedge clk);
		check(32'(ctl.beatQ.size()), 32'h0);
		axiWrite(ADDR_CTRL, 32'h1);
		axiWrite(8'h14, 32'h1);
		check(32'(resp), 32'(RESP_SLVERR));
		axiRead(8'h14);
		check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
		// reset lands in the middle of a live eight-beat burst
		ctl.issue(4'h5, 3'h0, 14'h0000);
		repeat (30) @(posedge clk);
		check(32'(dqOe), 32'h1);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		check(32'({dqOe, dqsOe, dqsOut, dqsNOut}), 32'h1);
		axiRead(ADDR_MODE);
		check(rd, 32'h3);
		printVerdict();
	end
endmodule
